// [logic/pmbc_core.sv]
// processor-mode and external-bus configuration registers with their
// derived pin-function, address-map and wait controls.
// assumes an Avalon-MM master on clk_sys_i, the strap and width pins
// arriving asynchronously, and the secondary reset sources on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
`include "pmbc_regs.svh"

module pmbc_core (
  // clock and hardware reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // secondary resets, one-cycle pulses on clk_sys_i
  input  wire logic        soft_rst_i,
  input  wire logic        wdt_rst_i,
  input  wire logic        osc_rst_i,
  // avalon-mm slave
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // pins and neighbouring logic
  input  wire logic        mode_strap_i,
  input  wire logic        byte_width_i,
  input  wire logic        cpu_rewrite_mode_flag_i,
  input  wire logic [19:0] cpu_addr_i,
  input  wire logic        int_access_i,
  input  wire logic        ext_access_i,
  // configuration outputs
  output logic [1:0]       mode_o,
  output logic             bus_pins_en_o,
  output logic [1:0]       bus_mode_o,
  output logic             mux_bus_o,
  output logic             data_8bit_o,
  output logic             mux_addr_shift_o,
  output logic             odd_addr_block_o,
  output logic             cs_area_256_o,
  output logic             p3_p4_gpio_o,
  output logic [1:0]       addr_width_o,
  output logic             addr_valid_o,
  output logic             rom_access_en_o,
  output logic             strobe_sel_o,
  output logic             wdt_reset_sel_o,
  output logic             int_wait_o,
  output logic [2:0]       addr_region_o,
  output logic             cfg_fault_o,
  output logic             sw_reset_req_o
);

  // ==========================================================
  // pin filters
  logic [`PMBC_SYNC_STAGES-1:0] strap_sync_q;
  logic [`PMBC_SYNC_STAGES-1:0] width_sync_q;
  logic                         strap_f_q;
  logic                         width_f_q;

  // three stages; the filtered level moves only when stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    strap_sync_q <= {strap_sync_q[1:0], mode_strap_i};
    width_sync_q <= {width_sync_q[1:0], byte_width_i};
    if (strap_sync_q[1] == strap_sync_q[2]) begin
      strap_f_q <= strap_sync_q[2];
    end
    if (width_sync_q[1] == width_sync_q[2]) begin
      width_f_q <= width_sync_q[2];
    end
  end

  // ==========================================================
  // state
  logic [1:0] settle_q;
  logic       ready_q;
  logic       rom_block_q;
  logic [1:0] mode_q;
  logic [7:2] m0_upper_q;
  logic [7:0] m1_q;
  logic       unlock_q;
  logic       wait_q;
  logic [7:0] rdata_q;
  logic       addr_undef_q;
  logic       int_wait_q;
  logic [2:0] region_q;
  logic       sw_rst_q;

  // ==========================================================
  // bus decode
  wire        soft_any   = soft_rst_i | wdt_rst_i | osc_rst_i;
  wire        req        = (avs_read_i | avs_write_i) & ready_q;
  wire        done       = req & ~wait_q;
  wire        wr_lane    = avs_write_i & avs_byteenable_i[0] & done;
  wire [7:0]  wd         = avs_writedata_i[7:0];
  wire        hit_m0     = avs_address_i == `PMBC_IDX_MODE_CTRL;
  wire        hit_m1     = avs_address_i == `PMBC_IDX_MODE_CTRL_EXT;
  wire        hit_pr     = avs_address_i == `PMBC_IDX_PROTECT;
  wire        hit_st     = avs_address_i == `PMBC_IDX_STATUS;
  wire        wr_m0      = wr_lane & hit_m0 & unlock_q;
  wire        wr_m1      = wr_lane & hit_m1 & unlock_q;
  wire        wr_pr      = wr_lane & hit_pr;
  wire [1:0]  wd_mode    = wd[`PMBC_M0_MODE_HI:`PMBC_M0_MODE_LO];

  // ==========================================================
  // derived configuration
  wire [1:0]  bus_mode   = m0_upper_q[`PMBC_M0_BUS_HI:`PMBC_M0_BUS_LO];
  wire        rewrite    = cpu_rewrite_mode_flag_i;
  wire        block_a    = m1_q[`PMBC_M1_BLOCK_A] | rewrite;
  wire        expand     = m1_q[`PMBC_M1_AREA_EXPAND] | rewrite;
  wire        wait_en    = m1_q[`PMBC_M1_INT_WAIT];
  wire [1:0]  aw_code    = {m1_q[`PMBC_M1_AW_HIGH], m0_upper_q[`PMBC_M0_AW_LOW]};
  wire        is_expand  = mode_q == pmbc_pkg::PMBC_MEM_EXPAND;
  wire        is_uproc   = mode_q == pmbc_pkg::PMBC_MICROPROC;
  wire        bus_on     = is_expand | is_uproc;
  wire        mux_any    = bus_on & (bus_mode != 2'h0);
  wire        mux_full   = is_expand & (bus_mode == 2'h3);
  wire        data8      = width_f_q | mux_full;
  // strap lock, microprocessor mode hides rom too
  wire        rom_en     = ~rom_block_q & ~is_uproc;
  wire        aw_bad     = aw_code == pmbc_pkg::PMBC_AW_BAD;
  wire [7:0]  m0_rd      = {m0_upper_q[7:4], 1'b0, m0_upper_q[2], mode_q};
  wire [7:0]  m1_rd      = (m1_q & `PMBC_M1_WRITABLE) |
                           {4'h0, expand, m1_q[`PMBC_M1_WDT_SEL], 1'b0, block_a};
  wire [7:0]  st_rd      = {aw_bad, rom_block_q, addr_undef_q, data8,
                            mux_any, bus_on, mode_q};
  wire [7:0]  rd_mux     = hit_m0 ? m0_rd :
                           hit_m1 ? m1_rd :
                           hit_pr ? {6'h0, unlock_q, 1'b0} :
                           hit_st ? st_rd : 8'h00;
  wire [2:0]  region     = region_of(cpu_addr_i, expand, rom_en, block_a, bus_on);

  // address map by area expansion bit
  function automatic logic [2:0] region_of(input logic [19:0] a,
                                           input logic        exp,
                                           input logic        rom,
                                           input logic        blka,
                                           input logic        ext);
    logic [2:0] r;
    r = ext ? pmbc_pkg::PMBC_RG_EXT : pmbc_pkg::PMBC_RG_RSVD;
    if (a < 20'h00400) begin
      r = pmbc_pkg::PMBC_RG_SFR;
    end else if (a < 20'h04000) begin
      r = pmbc_pkg::PMBC_RG_RAM;
    end else if (a < 20'h08000) begin
      if (exp) begin
        r = pmbc_pkg::PMBC_RG_RSVD;
      end
    end else if (a >= 20'h0f000 && a <= 20'h0ffff) begin
      if (blka && rom) begin
        r = pmbc_pkg::PMBC_RG_ROM;
      end
    end else if (a >= 20'hd0000) begin
      if (rom) begin
        r = pmbc_pkg::PMBC_RG_ROM;
      end
    end else if (a >= 20'h80000) begin
      if (exp) begin
        r = rom ? pmbc_pkg::PMBC_RG_ROM : pmbc_pkg::PMBC_RG_RSVD;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // strap capture: wait for the filter to settle after hardware reset
  // so the captured level is the one held during reset, not a glitch
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      settle_q <= 2'h0;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      settle_q <= settle_q + 2'h1;
      ready_q  <= settle_q == `PMBC_STRAP_SETTLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rom_block_q <= 1'b0;
    end else if (!ready_q && settle_q == `PMBC_STRAP_SETTLE) begin
      rom_block_q <= strap_f_q;
    end
  end

  // ==========================================================
  // mode field: only hardware reset touches it
  // mode kept over soft resets
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_q <= 2'(`PMBC_RST_MODE_CTRL & 8'h03);
    end else if (!ready_q && settle_q == `PMBC_STRAP_SETTLE) begin
      mode_q <= strap_f_q ? pmbc_pkg::PMBC_MICROPROC : pmbc_pkg::PMBC_SINGLE_CHIP;
    end else if (wr_m0 && wd_mode != pmbc_pkg::PMBC_FORBIDDEN) begin
      mode_q <= wd_mode;
    end
  end

  // remaining control bits fall back on any reset source
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || soft_any) begin
      m0_upper_q <= 6'(`PMBC_RST_MODE_CTRL >> 2);
      m1_q       <= `PMBC_RST_MODE_CTRL_EXT;
      unlock_q   <= 1'(`PMBC_RST_PROTECT >> `PMBC_PR_UNLOCK);
    end else begin
      if (wr_m0) begin
        m0_upper_q <= {wd[7:4], 1'b0, wd[`PMBC_M0_STROBE_SEL]};
      end
      if (wr_m1) begin
        m1_q <= (wd & `PMBC_M1_WRITABLE) | {5'h0, m1_q[`PMBC_M1_WDT_SEL] | wd[`PMBC_M1_WDT_SEL], 2'h0};
      end
      if (wr_pr) begin
        unlock_q <= wd[`PMBC_PR_UNLOCK];
      end
    end
  end

  // ==========================================================
  // bus handshake: waitrequest high until one cycle after a request
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= rd_mux;
    end
  end

  // software reset request pulse on a write of 1 to the reset bit
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= wr_m0 & wd[`PMBC_M0_SOFT_RESET];
    end
  end

  // ==========================================================
  // address undefined after entering expansion from single-chip mode
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_undef_q <= 1'b0;
    end else if (wr_m0 && mode_q == pmbc_pkg::PMBC_SINGLE_CHIP &&
                 wd_mode == pmbc_pkg::PMBC_MEM_EXPAND) begin
      addr_undef_q <= 1'b1;
    end else if (ext_access_i) begin
      addr_undef_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      int_wait_q <= 1'b0;
      region_q   <= pmbc_pkg::PMBC_RG_SFR;
    end else begin
      int_wait_q <= int_access_i & wait_en & ~int_wait_q;
      region_q   <= region;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_o           <= 2'h0;
      bus_pins_en_o    <= 1'b0;
      bus_mode_o       <= 2'h0;
      mux_bus_o        <= 1'b0;
      data_8bit_o      <= 1'b0;
      mux_addr_shift_o <= 1'b0;
      odd_addr_block_o <= 1'b0;
      cs_area_256_o    <= 1'b0;
      p3_p4_gpio_o     <= 1'b0;
      addr_width_o     <= 2'h0;
      rom_access_en_o  <= 1'b0;
      strobe_sel_o     <= 1'b0;
      wdt_reset_sel_o  <= 1'b0;
      cfg_fault_o      <= 1'b0;
    end else begin
      mode_o           <= mode_q;
      bus_pins_en_o    <= bus_on;
      bus_mode_o       <= bus_mode;
      mux_bus_o        <= mux_any;
      data_8bit_o      <= data8;
      mux_addr_shift_o <= mux_any & ~data8;
      odd_addr_block_o <= mux_any & ~data8;
      cs_area_256_o    <= mux_full;
      p3_p4_gpio_o     <= mux_full;
      addr_width_o     <= aw_code;
      rom_access_en_o  <= rom_en;
      strobe_sel_o     <= m0_upper_q[`PMBC_M0_STROBE_SEL] & ~data8;
      wdt_reset_sel_o  <= m1_q[`PMBC_M1_WDT_SEL];
      cfg_fault_o      <= aw_bad;
    end
  end

  // pass-through of flops that already hold the output value; addr_valid_o is the inverse of addr_undef_q
  assign avs_readdata_o    = {24'h0, rdata_q};
  assign avs_waitrequest_o = wait_q;
  assign addr_valid_o      = ~addr_undef_q;
  assign int_wait_o        = int_wait_q;
  assign addr_region_o     = region_q;
  assign sw_reset_req_o    = sw_rst_q;

endmodule

`default_nettype wire

// [logic/pmbc_regs.svh]
// register map, field positions, reset values and timing counts of the
// processor-mode and bus configuration block.
// assumes a 32-bit word-addressed bus; every register sits in bits 7:0.
`ifndef PMBC_REGS_SVH
`define PMBC_REGS_SVH

// ==========================================================
// word indexes (byte address is four times the index)
`define PMBC_IDX_MODE_CTRL      3'h0
`define PMBC_IDX_MODE_CTRL_EXT  3'h1
`define PMBC_IDX_PROTECT        3'h2
`define PMBC_IDX_STATUS         3'h3

// ==========================================================
// proc_mode_ctrl fields
`define PMBC_M0_MODE_LO         0
`define PMBC_M0_MODE_HI         1
`define PMBC_M0_STROBE_SEL      2
`define PMBC_M0_SOFT_RESET      3
`define PMBC_M0_BUS_LO          4
`define PMBC_M0_BUS_HI          5
`define PMBC_M0_AW_LOW          6
`define PMBC_M0_CLK_OUT_OFF     7

// proc_mode_ctrl_ext fields
`define PMBC_M1_BLOCK_A         0
`define PMBC_M1_AW_HIGH         1
`define PMBC_M1_WDT_SEL         2
`define PMBC_M1_AREA_EXPAND     3
`define PMBC_M1_INT_WAIT        7
`define PMBC_M1_WRITABLE        8'h8b

// protection_register fields
`define PMBC_PR_UNLOCK          1

// ==========================================================
// reset values
`define PMBC_RST_MODE_CTRL      8'h00
`define PMBC_RST_MODE_CTRL_EXT  8'h08
`define PMBC_RST_PROTECT        8'h00

// ==========================================================
// pin filter length and strap capture delay in clk_sys_i cycles
`define PMBC_SYNC_STAGES        3
`define PMBC_STRAP_SETTLE       2'h3

`endif

// [logic/pmbc_pkg.sv]
// types shared by the processor-mode and bus configuration block.
// assumes the register header is included by whoever needs offsets.
`default_nettype none
package pmbc_pkg;

  // ==========================================================
  // processor modes, encoded as in the mode field
  typedef enum logic [1:0] {
    PMBC_SINGLE_CHIP = 2'h0,
    PMBC_MEM_EXPAND  = 2'h1,
    PMBC_FORBIDDEN   = 2'h2,
    PMBC_MICROPROC   = 2'h3
  } pmbc_mode_t;

  // address bus width, encoded as {addr_width_high_bit, addr_width_low_bit}
  typedef enum logic [1:0] {
    PMBC_AW_20    = 2'h0,
    PMBC_AW_16    = 2'h1,
    PMBC_AW_BAD   = 2'h2,
    PMBC_AW_12    = 2'h3
  } pmbc_aw_t;

  // where a cpu address lands
  typedef enum logic [2:0] {
    PMBC_RG_SFR   = 3'h0,
    PMBC_RG_RAM   = 3'h1,
    PMBC_RG_ROM   = 3'h2,
    PMBC_RG_EXT   = 3'h3,
    PMBC_RG_RSVD  = 3'h4
  } pmbc_region_t;

endpackage

`default_nettype wire

// [test/pmbc_core_assertions.sv]
// port checker for the mode and bus configuration core.
// assumes it is bound to pmbc_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// checker
module pmbc_core_checker (
  // clock and resets
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        soft_rst_i,
  input wire logic        wdt_rst_i,
  input wire logic        osc_rst_i,
  // bus and access strobes
  input wire logic        avs_write_i,
  input wire logic        int_access_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  // configuration outputs
  input wire logic [1:0]  mode_o,
  input wire logic        bus_pins_en_o,
  input wire logic [1:0]  bus_mode_o,
  input wire logic        data_8bit_o,
  input wire logic        cs_area_256_o,
  input wire logic        p3_p4_gpio_o,
  input wire logic [1:0]  addr_width_o,
  input wire logic        cfg_fault_o,
  input wire logic        rom_access_en_o,
  input wire logic        wdt_reset_sel_o,
  input wire logic        int_wait_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // derived outputs are compared only once their source fields (mode, bus mode, address width) have settled
  mode_legal_a: assert property (mode_o != 2'h2)
    else $error("forbidden mode held");
  rom_off_a: assert property ($stable(mode_o) && rom_access_en_o |-> mode_o != 2'h3)
    else $error("rom open in microprocessor mode");
  ack_pulse_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0 ##1 avs_waitrequest_o)
    else $error("bad register answer");
  keep_mode_a: assert property ((soft_rst_i || wdt_rst_i || osc_rst_i) && avs_waitrequest_o && !avs_write_i
    |=> ##1 $stable(mode_o))
    else $error("mode lost at secondary reset");
  full_mux_a: assert property ($stable(mode_o) && $stable(bus_mode_o) |-> p3_p4_gpio_o == (mode_o == 2'h1
    && bus_mode_o == 2'h3) && cs_area_256_o == p3_p4_gpio_o && (!p3_p4_gpio_o || data_8bit_o))
    else $error("full multiplex pins wrong");
  wdt_sticky_a: assert property (wdt_reset_sel_o && !soft_rst_i && !wdt_rst_i && !osc_rst_i
    && !$past(soft_rst_i || wdt_rst_i || osc_rst_i) |=> wdt_reset_sel_o)
    else $error("watchdog select cleared");
  int_wait_a: assert property (int_wait_o |-> $past(int_access_i) ##1 !int_wait_o)
    else $error("stray internal wait");
  pins_mode_a: assert property ($stable(mode_o) |-> bus_pins_en_o == mode_o[0])
    else $error("bus pins disagree with mode");
  aw_fault_a: assert property ($stable(addr_width_o) |-> cfg_fault_o == (addr_width_o == 2'h2))
    else $error("width fault flag wrong");
endmodule

bind pmbc_core pmbc_core_checker i_pmbc_core_checker (
  .clk_sys_i, .sys_rst_i, .soft_rst_i, .wdt_rst_i, .osc_rst_i,
  .avs_write_i, .int_access_i, .avs_waitrequest_o, .avs_readdata_o,
  .mode_o, .bus_pins_en_o, .bus_mode_o, .data_8bit_o, .cs_area_256_o,
  .p3_p4_gpio_o, .addr_width_o, .cfg_fault_o, .rom_access_en_o,
  .wdt_reset_sel_o, .int_wait_o
);
`default_nettype wire

// [test/pmbc_ext_model.sv]
// model of external memory on the expansion bus: width pin and accesses.
// assumes the core's pin-enable output and a request strobe from the bench.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external bus partner
module pmbc_ext_model #(
  parameter logic       WIDTH8 = 1'b0,
  parameter logic [3:0] LAT    = 4'h1
) (
  // clock and request from the bench, pin enable from the core
  input  wire logic clk_sys_i,
  input  wire logic bus_pins_en_i,
  input  wire logic go_i,
  // pins towards the core
  output logic      byte_width_o,
  output logic      ext_access_o
);
  logic [3:0] cnt_q = 4'h0;
  assign byte_width_o = WIDTH8;
  // access only while bus pins live
  always_ff @(posedge clk_sys_i) begin
    if (go_i && bus_pins_en_i && cnt_q == 4'h0) begin
      cnt_q <= LAT;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // one-cycle strobe; a slow device answers late
  assign ext_access_o = (cnt_q == 4'h1);
endmodule
`default_nettype wire

// [test/test_pmbc_core.sv]
// self-checking bench for the mode and bus configuration core.
// assumes the core, its bound checker and the external bus model.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module test_pmbc_core;
  // stimulus
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, mode_strap_i = 1'b0;
  logic soft_rst_i = 1'b0, wdt_rst_i = 1'b0, osc_rst_i = 1'b0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, ext_go = 1'b0;
  logic [2:0] avs_address_i = 3'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic cpu_rewrite_mode_flag_i = 1'b0, int_access_i = 1'b0;
  logic [19:0] cpu_addr_i = 20'h0;
  // observed
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, byte_width_i, ext_access_i, bus_pins_en_o, mux_bus_o;
  logic data_8bit_o, mux_addr_shift_o, odd_addr_block_o, cs_area_256_o, p3_p4_gpio_o;
  logic addr_valid_o, rom_access_en_o, wdt_reset_sel_o, int_wait_o, cfg_fault_o;
  logic [1:0] mode_o, bus_mode_o, addr_width_o;
  logic [2:0] addr_region_o;
  logic strobe_sel_o, sw_reset_req_o;
  int errors = 0;
  int compares = 0;

  pmbc_core i_pmbc_core (.clk_sys_i, .sys_rst_i, .soft_rst_i, .wdt_rst_i, .osc_rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .mode_strap_i, .byte_width_i,
    .cpu_rewrite_mode_flag_i, .cpu_addr_i, .int_access_i, .ext_access_i, .mode_o,
    .bus_pins_en_o, .bus_mode_o, .mux_bus_o, .data_8bit_o, .mux_addr_shift_o,
    .odd_addr_block_o, .cs_area_256_o, .p3_p4_gpio_o, .addr_width_o, .addr_valid_o,
    .rom_access_en_o, .strobe_sel_o, .wdt_reset_sel_o, .int_wait_o, .addr_region_o,
    .cfg_fault_o, .sw_reset_req_o);
  // slow far side with a 16-bit width strap
  pmbc_ext_model #(.WIDTH8(1'b0), .LAT(4'h6)) i_pmbc_ext_model (.clk_sys_i,
    .bus_pins_en_i(bus_pins_en_o), .go_i(ext_go), .byte_width_o(byte_width_i),
    .ext_access_o(ext_access_i));

  always #20 clk_sys_i = ~clk_sys_i;

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon transfer; released only at the edge that sees the answer
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    // only the watchdog ends a wait that never sees the answer
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    if (!w) chk(avs_readdata_o, {24'h0, e});
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h0);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic reset(input logic s);
    mode_strap_i <= s;
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic region(input logic [19:0] a, input logic [2:0] e);
    cpu_addr_i <= a;
    repeat (2) @(posedge clk_sys_i);
    chk(addr_region_o, e);
  endtask
  task automatic iw(input logic e);
    int_access_i <= 1'b1;
    @(posedge clk_sys_i);
    int_access_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(int_wait_o, e);
    @(posedge clk_sys_i);
    chk(int_wait_o, 1'b0);
  endtask
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    reset(1'b0);
    rd(`PMBC_IDX_MODE_CTRL, `PMBC_RST_MODE_CTRL);
    rd(`PMBC_IDX_MODE_CTRL_EXT, `PMBC_RST_MODE_CTRL_EXT);
    wr(0, 8'h01);
    rd(0, 8'h00);
    wr(2, 8'h02);
    wr(0, 8'h01);
    settle();
    chk({mode_o, bus_pins_en_o, addr_valid_o, rom_access_en_o}, 5'b01101);
    ext_go <= 1'b1;
    @(posedge clk_sys_i);
    ext_go <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk(addr_valid_o, 1'b1);
    wr(0, 8'h02);
    settle();
    chk(mode_o, 2'h1);
    wr(0, 8'h30);
    wr(0, 8'h31);
    settle();
    chk({p3_p4_gpio_o, cs_area_256_o, data_8bit_o, mux_bus_o, mux_addr_shift_o}, 5'b11110);
    wr(0, 8'h10);
    wr(0, 8'h11);
    settle();
    chk({mux_bus_o, mux_addr_shift_o, odd_addr_block_o, data_8bit_o, p3_p4_gpio_o}, 5'b11100);
    wr(0, 8'h00);
    wr(0, 8'h01);
    settle();
    chk(mux_bus_o, 1'b0);
    region(20'h05000, 3'h4);
    wr(1, 8'h00);
    region(20'h05000, 3'h3);
    region(20'h90000, 3'h3);
    region(20'h02000, 3'h1);
    region(20'he0000, 3'h2);
    wr(1, 8'h01);
    region(20'h0f000, 3'h2);
    wr(0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(0, {1'b0, i[0], 6'h0});
      wr(1, {6'h0, i[1], 1'b0});
      settle();
      chk({cfg_fault_o, addr_width_o}, {i == 2, i[1:0]});
    end
    wr(0, 8'h41);
    wr(1, 8'h04);
    wr(1, 8'h00);
    rd(1, 8'h04);
    for (int k = 0; k < 3; k++) begin
      soft_rst_i <= (k == 0);
      wdt_rst_i <= (k == 1);
      osc_rst_i <= (k == 2);
      @(posedge clk_sys_i);
      {soft_rst_i, wdt_rst_i, osc_rst_i} <= 3'h0;
      settle();
      chk({mode_o, wdt_reset_sel_o}, 3'b010);
      rd(2, 8'h00);
      wr(2, 8'h02);
    end
    cpu_rewrite_mode_flag_i <= 1'b1;
    wr(1, 8'h00);
    rd(1, 8'h09);
    cpu_rewrite_mode_flag_i <= 1'b0;
    rd(1, 8'h00);
    wr(1, 8'h80);
    iw(1'b1);
    wr(1, 8'h00);
    iw(1'b0);
    wr(5, 8'hff);
    rd(5, 8'h00);
    reset(1'b1);
    chk({mode_o, rom_access_en_o}, 3'b110);
    wr(2, 8'h02);
    wr(0, 8'h00);
    settle();
    chk({mode_o, rom_access_en_o, bus_pins_en_o}, 4'b0000);
    rd(3, 8'h40);
    wr(0, 8'h0c);
    chk(sw_reset_req_o, 1'b1);
    settle();
    chk({sw_reset_req_o, strobe_sel_o, mode_o}, 4'b0100);
    print_verdict();
  end

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
